// *** host_port_pkg.sv ***
// constants for the parallel host port block: register indices,
// field positions and reset values.
// assumes a 32-bit avalon-mm slave, one word per register index.
package host_port_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA_LATCH  = 8'h08; // parallel data
    localparam logic [7:0] IDX_CTRL_PINS   = 8'h09; // control pins
    localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c; // irq flags one
    localparam logic [7:0] IDX_DATA_DIR    = 8'h88; // data direction
    localparam logic [7:0] IDX_CTRL_DIR    = 8'h89; // dir and status
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c; // irq enables one
    localparam logic [7:0] IDX_ANALOG_CFG  = 8'h9f; // analog config

    // fields of control_dir_and_host_status
    localparam int BIT_IBF  = 7; // input buffer full
    localparam int BIT_OBF  = 6; // output buffer full
    localparam int BIT_INPUT_BUFFER_OVERFLOW = 5; // input overflow
    localparam int BIT_MODE = 4; // host port mode select
    localparam int BIT_GAP  = 3; // unimplemented
    localparam int DIR_MSB  = 2; // control pin direction bits

    // host port flag and enable position in the irq registers
    localparam int BIT_HOST_IRQ = 7;

    // pins of the control port in host mode
    localparam int PIN_READ   = 0; // read strobe, active low
    localparam int PIN_WRITE  = 1; // write strobe, active low
    localparam int PIN_SELECT = 2; // chip select, active low

    // analog select code that makes all control pins digital
    localparam logic [2:0] ANALOG_ALL_DIGITAL = 3'h7;

    // reset values
    localparam logic [7:0] RST_CTRL_DIR    = 8'h07;
    localparam logic [7:0] RST_DATA_DIR    = 8'hff;
    localparam logic [7:0] RST_IRQ_FLAGS   = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
    localparam logic [2:0] RST_ANALOG_SEL  = 3'h0;
    localparam logic [7:0] RST_LATCH       = 8'h00;
    localparam logic [2:0] RST_STROBES     = 3'h7; // idle high
endpackage

// *** host_port.sv ***
// parallel slave host port with three control pins and an
// avalon-mm register slave.
// assumes all pins arrive asynchronous to clk_in and that an
// outside resolver forms the pad levels from the enables.
module host_port
    import host_port_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [9:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [7:0]  data_pins_in,
    output logic      [7:0]  data_pins_out,
    output logic      [7:0]  data_pins_oe_out,
    input  wire logic [2:0]  ctrl_pins_in,
    output logic      [2:0]  ctrl_pins_out,
    output logic      [2:0]  ctrl_pins_oe_out,
    output logic             host_port_irq_out
);
    // bus handshake and read data
    logic        wait_q;       // waitrequest flop
    logic        wait_d;
    logic [31:0] rdata_q;      // read data flop
    logic [31:0] rdata_d;

    // pin synchronisers, first stage read only by second
    logic [7:0]  data_meta_q;
    logic [7:0]  data_sync_q;
    logic [2:0]  ctrl_meta_q;
    logic [2:0]  ctrl_sync_q;

    // latches and registers
    logic [7:0]  out_latch_q;  // written by software
    logic [7:0]  in_latch_q;   // filled by external writes
    logic [7:0]  in_latch_d;
    logic [7:0]  hold_q;       // pins seen during a write
    logic [2:0]  ctrl_latch_q; // control port output latch
    logic [7:0]  data_dir_q;   // data direction, 1 = input
    logic [2:0]  ctrl_dir_q;   // control direction, 1 = input
    logic        mode_q;       // host port mode select
    logic        ibf_q;
    logic        ibf_d;
    logic        obf_q;
    logic        obf_d;
    logic        input_buffer_overflow_q;
    logic        input_buffer_overflow_d;
    logic        flag_q;       // host port irq flag
    logic        flag_d;
    logic [6:0]  flags_rest_q; // other irq flag bits
    logic [7:0]  enables_q;    // irq enables one
    logic [2:0]  analog_q;     // analog pin select
    logic        sel_rd_q;     // qualified read seen
    logic        sel_wr_q;     // qualified write seen
    logic [7:0]  data_oe_q;
    logic [7:0]  data_oe_d;
    logic [7:0]  data_o_q;
    logic [2:0]  ctrl_oe_q;
    logic [2:0]  ctrl_o_q;
    logic        irq_q;

    // decode of the bus request
    wire        req      = avs_read_in | avs_write_in;
    wire        acc      = req & ~wait_q;  // access edge
    wire        rd_load  = req & wait_q;   // sample for read
    wire        sw_rd    = acc & avs_read_in;
    wire        sw_wr    = acc & avs_write_in
                         & avs_byteenable_in[0];
    wire [7:0]  idx      = avs_address_in[9:2];
    wire [7:0]  wdata    = avs_writedata_in[7:0];

    // one-word decode used for every register
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] b);
        hit = (a == b);
    endfunction

    wire wr_data    = sw_wr & hit(idx, IDX_DATA_LATCH);
    wire wr_ctrl    = sw_wr & hit(idx, IDX_CTRL_PINS);
    wire wr_flags   = sw_wr & hit(idx, IDX_IRQ_FLAGS);
    wire wr_ddir    = sw_wr & hit(idx, IDX_DATA_DIR);
    wire wr_cdir    = sw_wr & hit(idx, IDX_CTRL_DIR);
    wire wr_enables = sw_wr & hit(idx, IDX_IRQ_ENABLES);
    wire wr_analog  = sw_wr & hit(idx, IDX_ANALOG_CFG);
    wire rd_data    = sw_rd & hit(idx, IDX_DATA_LATCH);

    // strobes after synchronisation, active low
    wire rd_n  = ctrl_sync_q[PIN_READ];
    wire wr_n  = ctrl_sync_q[PIN_WRITE];
    wire cs_n  = ctrl_sync_q[PIN_SELECT];

    // select gates both strobes; mode gates the pins
    wire sel_rd = mode_q & ~cs_n & ~rd_n;
    wire sel_wr = mode_q & ~cs_n & ~wr_n;

    // transfer completes when a qualified strobe ends
    wire rd_done = sel_rd_q & ~sel_rd;
    wire wr_done = sel_wr_q & ~sel_wr;

    // pins selected as analog; reset select keeps all analog
    wire analog_pins = (analog_q != ANALOG_ALL_DIGITAL);

    // control pin readback, analog pins read as zero
    wire [2:0] ctrl_view = analog_pins ? 3'h0 : ctrl_sync_q;

    // data readback: input latch in host mode, pins otherwise
    wire [7:0] data_view = mode_q ? in_latch_q
                                  : data_sync_q;

    // status word with the gap bit tied low
    wire [7:0] status_view = {ibf_q, obf_q, input_buffer_overflow_q, mode_q,
                              1'b0, ctrl_dir_q};

    // read multiplexer; unmapped words read as zero
    always_comb begin
        rdata_d = 32'h0;
        case (idx)
            IDX_DATA_LATCH:  rdata_d[7:0] = data_view;
            IDX_CTRL_PINS:   rdata_d[2:0] = ctrl_view;
            IDX_IRQ_FLAGS:   rdata_d[7:0] = {flag_q, flags_rest_q};
            IDX_DATA_DIR:    rdata_d[7:0] = data_dir_q;
            IDX_CTRL_DIR:    rdata_d[7:0] = status_view;
            IDX_IRQ_ENABLES: rdata_d[7:0] = enables_q;
            IDX_ANALOG_CFG:  rdata_d[2:0] = analog_q;
            default:         rdata_d = 32'h0;
        endcase
    end

    // one wait cycle per access, then release
    assign wait_d = ~(req & wait_q);

    // bus handshake; read data sampled in the first cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= wait_d;
            if (rd_load) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // two flops on every pin before any logic looks at it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            data_meta_q <= RST_LATCH;
            data_sync_q <= RST_LATCH;
            ctrl_meta_q <= RST_STROBES;
            ctrl_sync_q <= RST_STROBES;
        end else begin
            data_meta_q <= data_pins_in;
            data_sync_q <= data_meta_q;
            ctrl_meta_q <= ctrl_pins_in;
            ctrl_sync_q <= ctrl_meta_q;
        end
    end

    // input latch only accepts when the last word was taken
    assign in_latch_d = (wr_done & ~ibf_q) ? hold_q
                                           : in_latch_q;

    // full flags: software set of output full wins over the read clear
    assign ibf_d = mode_q & ((wr_done & ~ibf_q)
                 | (ibf_q & ~rd_data));
    assign obf_d = mode_q & (wr_data
                 | (obf_q & ~rd_done));

    // overflow has no mode gate; every wr_cdir, mode change included, loads it from bit five, but an overflow set in the same cycle wins
    assign input_buffer_overflow_d = (wr_done & ibf_q)
                  | (wr_cdir ? wdata[BIT_INPUT_BUFFER_OVERFLOW] : input_buffer_overflow_q);

    // irq flag set by any finished transfer, set wins
    assign flag_d = rd_done | wr_done
                  | (wr_flags ? wdata[BIT_HOST_IRQ] : flag_q);

    // transfer tracking and the buffer flags
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sel_rd_q   <= 1'b0;
            sel_wr_q   <= 1'b0;
            hold_q     <= RST_LATCH;
            in_latch_q <= RST_LATCH;
            ibf_q      <= 1'b0;
            obf_q      <= 1'b0;
            input_buffer_overflow_q     <= 1'b0;
            flag_q     <= 1'b0;
        end else begin
            sel_rd_q   <= sel_rd;
            sel_wr_q   <= sel_wr;
            // keep the last pin value seen while writing
            // data and strobes share one sync depth, so the word lines up
            if (sel_wr) begin
                hold_q <= data_sync_q;
            end
            in_latch_q <= in_latch_d;
            ibf_q      <= ibf_d;
            obf_q      <= obf_d;
            input_buffer_overflow_q     <= input_buffer_overflow_d;
            flag_q     <= flag_d;
        end
    end

    // software registers; writes land at the access edge
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            out_latch_q  <= RST_LATCH;
            ctrl_latch_q <= 3'h0;
            data_dir_q   <= RST_DATA_DIR;
            ctrl_dir_q   <= RST_CTRL_DIR[DIR_MSB:0];
            mode_q       <= RST_CTRL_DIR[BIT_MODE];
            flags_rest_q <= RST_IRQ_FLAGS[6:0];
            enables_q    <= RST_IRQ_ENABLES;
            analog_q     <= RST_ANALOG_SEL;
        end else begin
            if (wr_data) begin
                out_latch_q <= wdata;
            end
            if (wr_ctrl) begin
                ctrl_latch_q <= wdata[2:0];
            end
            if (wr_ddir) begin
                data_dir_q <= wdata;
            end
            // status bits seven and six are read only
            if (wr_cdir) begin
                ctrl_dir_q <= wdata[DIR_MSB:0];
                mode_q     <= wdata[BIT_MODE];
            end
            if (wr_flags) begin
                flags_rest_q <= wdata[6:0];
            end
            if (wr_enables) begin
                enables_q <= wdata;
            end
            if (wr_analog) begin
                analog_q <= wdata[2:0];
            end
        end
    end

    // data pins: strobes steer them in host mode
    assign data_oe_d = mode_q ? {8{sel_rd}}
                              : ~data_dir_q;

    // pin drivers and the masked interrupt
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            data_oe_q <= 8'h00;
            data_o_q  <= RST_LATCH;
            ctrl_oe_q <= 3'h0;
            ctrl_o_q  <= 3'h0;
            irq_q     <= 1'b0;
        end else begin
            data_oe_q <= data_oe_d;
            data_o_q  <= out_latch_q;
            // direction holds even for analog pins
            ctrl_oe_q <= ~ctrl_dir_q;
            ctrl_o_q  <= ctrl_latch_q;
            irq_q     <= flag_q & enables_q[BIT_HOST_IRQ];
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign data_pins_out       = data_o_q;
    assign data_pins_oe_out    = data_oe_q;
    assign ctrl_pins_out       = ctrl_o_q;
    assign ctrl_pins_oe_out    = ctrl_oe_q;
    assign host_port_irq_out   = irq_q;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    a_input_buffer_overflow_keeps_word: assert property (
        wr_done && ibf_q |=> input_buffer_overflow_q && $stable(in_latch_q))
        else $error("overflow lost or word replaced");

    a_ibf_on_write: assert property (
        wr_done && !ibf_q && mode_q |=> ibf_q
            && in_latch_q == $past(hold_q))
        else $error("external write not latched");

    a_obf_ext_read: assert property (
        rd_done && !wr_data |=> !obf_q)
        else $error("output full not cleared");

    a_flag_on_done: assert property (
        rd_done || wr_done |=> flag_q ##1 irq_q == enables_q[BIT_HOST_IRQ])
        else $error("irq flag not set on transfer");

    a_gap_bit_zero: assert property (
        rd_load && idx == IDX_CTRL_DIR |=> !avs_readdata_out[3])
        else $error("status bit three not zero");

    a_analog_reads_0: assert property (
        rd_load && idx == IDX_CTRL_PINS && analog_pins
            |=> avs_readdata_out[2:0] == 3'h0)
        else $error("analog pin read not zero");

    a_unsel_no_done: assert property (
        cs_n && $past(cs_n) |-> !rd_done && !wr_done)
        else $error("transfer while unselected");

    a_read_drives: assert property (
        mode_q && sel_rd |=> data_pins_oe_out == 8'hff
            && data_pins_out == $past(out_latch_q))
        else $error("read strobe did not drive pins");

    a_io_flags_low: assert property (
        !mode_q |=> !ibf_q && !obf_q)
        else $error("full flags set outside host mode");

    a_wait_one_cycle: assert property (
        req && wait_q |=> !avs_waitrequest_out)
        else $error("waitrequest not released");

    a_dir_drives: assert property (
        1'b1 |=> ctrl_pins_oe_out == ~$past(ctrl_dir_q))
        else $error("control direction not applied");

    // guards on the clears, the sticky overflow and the latch steering
    a_ibf_sw_clear: assert property (
        rd_data && ibf_q && !wr_done |=> !ibf_q)
        else $error("input full not cleared by read");

    a_obf_sw_write: assert property (
        wr_data && mode_q |=> obf_q)
        else $error("output full not set by write");

    a_input_buffer_overflow_sticky: assert property (
        input_buffer_overflow_q && !wr_cdir |=> input_buffer_overflow_q)
        else $error("overflow cleared without a write");

    a_flag_sw_clear: assert property (
        wr_flags && !wdata[BIT_HOST_IRQ] && !rd_done && !wr_done
            |=> !flag_q)
        else $error("irq flag not cleared by software");

    a_in_latch_steady: assert property (
        !wr_done |=> $stable(in_latch_q))
        else $error("input latch changed without a write");

    a_host_dir_ignored: assert property (
        mode_q && !sel_rd |=> data_pins_oe_out == 8'h00)
        else $error("data pins driven without a read");
endmodule

// *** ext_cpu.sv ***
// model of the external processor on the parallel data pins and strobes
// assumes the bench resolves each data pad from the device's enables alone
module ext_cpu (
    input  wire logic [7:0] bus_level_in,   // resolved data pad levels
    input  wire logic       clk_in,         // bench clock, steps the model
    output logic      [7:0] data_drive_out, // our data, or inverse when off
    output logic      [2:0] strobes_out     // cs_n, wr_n, rd_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: no strobe low, device unselected
    initial begin
        strobes_out    = 3'h7;
        data_drive_out = 8'h00;
    end

    // one write; sel_n high tries a write with the device unselected
    // data held well past the strobe rise so the syncs see it settled
    task automatic host_write(input logic [7:0] d, input logic sel_n);
        @(posedge clk_in);
        strobes_out    <= {sel_n, 2'b01};
        data_drive_out <= d;
        repeat (4) @(posedge clk_in);
        strobes_out <= 3'h7;
        repeat (4) @(posedge clk_in);
        data_drive_out <= ~d; // released: never leave the old value showing
    endtask

    // one read; the device drives the pads while both strobes are low
    task automatic host_read(output logic [7:0] d);
        @(posedge clk_in);
        strobes_out <= 3'b010;
        repeat (5) @(posedge clk_in);
        d = bus_level_in;
        strobes_out <= 3'h7;
        repeat (5) @(posedge clk_in);
    endtask
endmodule

// *** testbench.sv ***
// self-checking bench: avalon-mm master plus external processor model
// assumes one 200 mhz clock and the register map of host_port_pkg
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import host_port_pkg::*;

    logic        clk_in;              // 5 ns period
    logic        reset_in;            // sync, active high
    logic [9:0]  avs_address_in;      // byte address
    logic        avs_read_in;         // read request
    logic        avs_write_in;        // write request
    logic [31:0] avs_writedata_in;    // write data
    logic [3:0]  avs_byteenable_in;   // byte lanes
    logic [31:0] avs_readdata_out;    // read data
    logic        avs_waitrequest_out; // low at completion
    logic [7:0]  data_pins_out;       // device data drive
    logic [7:0]  data_pins_oe_out;    // device data enable
    logic [7:0]  data_drive;          // processor data drive
    logic [7:0]  data_level;          // resolved pads
    logic [2:0]  strobes;             // processor strobes
    logic [2:0]  ctrl_pins_out;       // control port latch
    logic [2:0]  ctrl_pins_oe_out;    // control port enables
    logic        host_port_irq_out;   // masked interrupt
    logic [31:0] exp_q[$];            // expected read data, oldest first
    int          fail_count = 0;      // mismatches
    int          n_tests    = 0;      // comparisons
    int          cycles     = 0;      // timeout counter

    // pad resolution bit by bit; device wins where it drives
    assign data_level = (data_pins_oe_out & data_pins_out) |
                        (~data_pins_oe_out & data_drive);

    host_port host_port_inst (
        .clk_in              (clk_in),
        .reset_in            (reset_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .data_pins_in        (data_level),
        .data_pins_out       (data_pins_out),
        .data_pins_oe_out    (data_pins_oe_out),
        .ctrl_pins_in        (strobes),
        .ctrl_pins_out       (ctrl_pins_out),
        .ctrl_pins_oe_out    (ctrl_pins_oe_out),
        .host_port_irq_out   (host_port_irq_out)
    );

    ext_cpu ext_cpu_inst (
        .bus_level_in   (data_level),
        .clk_in         (clk_in),
        .data_drive_out (data_drive),
        .strobes_out    (strobes)
    );

    // clock
    always #2.5 clk_in = ~clk_in;

    // one comparison; mismatch reported at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // closing report, the only end of the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one avalon access; request held until waitrequest is seen low
    task automatic bus_op(input logic [7:0] idx, input logic wr,
                          input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_in);
        avs_address_in    <= {idx, 2'b00};
        avs_write_in      <= wr;
        avs_read_in       <= ~wr;
        avs_writedata_in  <= {24'h000000, d};
        avs_byteenable_in <= be;
        // no local limit: only the hang guard ends a wait
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        bus_op(idx, 1'b1, d, 4'h1);
    endtask

    // read with its expected value noted for the monitor
    task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
        exp_q.push_back({24'h000000, exp});
        bus_op(idx, 1'b0, 8'h00, 4'h1);
    endtask

    // monitor: read data taken at the completing edge only
    always @(posedge clk_in) begin
        if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
            if (exp_q.size() > 0) begin
                check(avs_readdata_out, exp_q.pop_front());
            end
        end
    end

    // hang guard; the run needs a few hundred cycles at most
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        logic [7:0] rd;
        clk_in            = 1'b0;
        reset_in          = 1'b1;
        avs_address_in    = 10'h000;
        avs_read_in       = 1'b0;
        avs_write_in      = 1'b0;
        avs_writedata_in  = 32'h00000000;
        avs_byteenable_in = 4'h0;
        rd = 8'($urandom(32'h55ea6ad9));
        d1 = 8'($urandom());
        d2 = 8'($urandom());
        d3 = ~d2; // differs from d2 so a lost word shows
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        // reset values and unmapped or lane-masked accesses
        reg_rd(IDX_CTRL_DIR, RST_CTRL_DIR);
        reg_rd(IDX_CTRL_PINS, 8'h00);
        reg_rd(IDX_IRQ_FLAGS, RST_IRQ_FLAGS);
        reg_rd(IDX_DATA_DIR, RST_DATA_DIR);
        reg_rd(8'h01, 8'h00);
        bus_op(IDX_IRQ_ENABLES, 1'b1, 8'hff, 4'h0);
        reg_rd(IDX_IRQ_ENABLES, 8'h00);
        // direction bits steer the pins while still analog
        reg_wr(IDX_CTRL_DIR, 8'h0a);
        repeat (2) @(posedge clk_in);
        check(32'(ctrl_pins_oe_out), 32'h5);
        reg_rd(IDX_CTRL_DIR, 8'h02);
        reg_wr(IDX_CTRL_DIR, 8'h07);
        reg_wr(IDX_ANALOG_CFG, {5'h00, ANALOG_ALL_DIGITAL});
        reg_rd(IDX_CTRL_PINS, 8'h07);
        // control latch goes to its pins; readback still shows the pins
        reg_wr(IDX_CTRL_PINS, d2);
        repeat (2) @(posedge clk_in);
        check(32'(ctrl_pins_out), 32'(d2[2:0]));
        reg_rd(IDX_CTRL_PINS, 8'h07);
        // io mode: data latch out on the pads, read back from the pads
        reg_wr(IDX_DATA_DIR, 8'h00);
        reg_wr(IDX_DATA_LATCH, d1);
        repeat (4) @(posedge clk_in);
        check(32'(data_pins_oe_out), 32'hff);
        reg_rd(IDX_DATA_LATCH, d1);
        // host mode ignores the data direction register
        reg_wr(IDX_CTRL_DIR, 8'h17);
        repeat (3) @(posedge clk_in);
        check(32'(data_pins_oe_out), 32'h00);
        // external write, then a second one while still unread
        ext_cpu_inst.host_write(d2, 1'b0);
        reg_rd(IDX_CTRL_DIR, 8'h97);
        reg_rd(IDX_IRQ_FLAGS, 8'h80);
        check(32'(host_port_irq_out), 32'h0);
        ext_cpu_inst.host_write(d3, 1'b0);
        reg_rd(IDX_CTRL_DIR, 8'hb7);
        reg_rd(IDX_DATA_LATCH, d2);
        reg_rd(IDX_CTRL_DIR, 8'h37);
        reg_wr(IDX_CTRL_DIR, 8'h17);
        reg_rd(IDX_CTRL_DIR, 8'h17);
        // unselected write changes nothing
        ext_cpu_inst.host_write(d3, 1'b1);
        reg_rd(IDX_CTRL_DIR, 8'h17);
        // software write fills the output side, enable unmasks irq
        reg_wr(IDX_DATA_LATCH, d1);
        reg_rd(IDX_CTRL_DIR, 8'h57);
        reg_wr(IDX_IRQ_ENABLES, 8'h80);
        repeat (2) @(posedge clk_in);
        check(32'(host_port_irq_out), 32'h1);
        reg_wr(IDX_IRQ_FLAGS, 8'h00);
        repeat (2) @(posedge clk_in);
        check(32'(host_port_irq_out), 32'h0);
        // external read takes the output latch and sets the flag
        ext_cpu_inst.host_read(rd);
        check(32'(rd), 32'(d1));
        reg_rd(IDX_CTRL_DIR, 8'h17);
        check(32'(host_port_irq_out), 32'h1);
        // leaving host mode clears a pending output-full flag
        reg_wr(IDX_DATA_LATCH, d3);
        reg_wr(IDX_CTRL_DIR, 8'h07);
        reg_rd(IDX_CTRL_DIR, 8'h07);
        repeat (2) @(posedge clk_in);
        // every noted read must have been seen by the monitor
        check(32'(exp_q.size()), 32'h0);
        give_verdict();
    end
endmodule
